// ===== rtl/ljsr_pkg.sv
/*
  Constants for the LED and jumper status register bank: register byte
  addresses, field positions, reset values and register widths.
  Assumes a 32-bit register address and one system clock.
*/
package ljsr_pkg;
  localparam int unsigned ADDR_W = 32;
  localparam int unsigned DATA_W = 8;
  localparam logic [31:0] LED_CTRL_ADDR  = 32'h80840020;
  localparam logic [31:0] JUMPER_A_ADDR  = 32'h10800000;
  localparam logic [31:0] JUMPER_B_ADDR  = 32'h22800000;
  localparam int unsigned LED_GREEN_BIT  = 0;
  localparam int unsigned LED_RED_BIT    = 1;
  localparam int unsigned CONSOLE_EN_BIT = 0;
  localparam int unsigned FLASH_WE_BIT   = 1;
  localparam int unsigned CONS_SWAP_BIT  = 3;
  localparam int unsigned USER1_BIT      = 4;
  localparam int unsigned USER2_BIT      = 0;
  localparam logic [7:0]  LED_RESET      = 8'h03;
  localparam logic [7:0]  READ_ZERO      = 8'h00;
endpackage

// ===== rtl/ljsr_jumper_if.sv
/*
  Carries the jumper fitted flags, all normalised to one meaning fitted,
  from the jumper sampler to the register bank.
  Assumes one clock domain.
*/
`timescale 1ns/100ps
interface ljsr_jumper_if;
  logic console_enable_jumper;
  logic flash_write_enable_jumper;
  logic console_swap_jumper;
  logic first_user_jumper;
  logic second_user_jumper;
  modport src (output console_enable_jumper, flash_write_enable_jumper,
               console_swap_jumper, first_user_jumper, second_user_jumper);
  modport dst (input console_enable_jumper, flash_write_enable_jumper,
               console_swap_jumper, first_user_jumper, second_user_jumper);
endinterface

// ===== rtl/ljsr_jumper_sample.sv
/*
  Registers the jumper pins once per clock; the pins are active high
  (high when fitted). Assumes pins are static straps, synchronous to clk.
*/
`timescale 1ns/100ps
module ljsr_jumper_sample (
  input  wire logic clk_sys_i,
  input  wire logic reset_i,
  input  wire logic console_enable_jumper_i,
  input  wire logic flash_write_enable_jumper_i,
  input  wire logic console_swap_jumper_i,
  input  wire logic first_user_jumper_i,
  input  wire logic second_user_jumper_i,
  ljsr_jumper_if.src jmp
);
  // one register stage so reads see a stable value
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      jmp.console_enable_jumper     <= 1'b0;
      jmp.flash_write_enable_jumper <= 1'b0; // safe: protected at reset
      jmp.console_swap_jumper       <= 1'b0;
      jmp.first_user_jumper         <= 1'b0;
      jmp.second_user_jumper        <= 1'b0;
    end else begin
      jmp.console_enable_jumper     <= console_enable_jumper_i;
      jmp.flash_write_enable_jumper <= flash_write_enable_jumper_i;
      jmp.console_swap_jumper       <= console_swap_jumper_i;
      jmp.first_user_jumper         <= first_user_jumper_i;
      jmp.second_user_jumper        <= second_user_jumper_i;
    end
  end
endmodule

// ===== rtl/ljsr_led_jumper_regs.sv
/*
  LED and jumper status register bank: LED control register, two
  read-only jumper registers, and the flash write gate.
  Assumes a plain register port with read data one cycle after the read
  strobe, jumper pins high when fitted, and one synchronous reset.
*/
// Decided for this implementation: the plain strobed port.
`timescale 1ns/100ps
module ljsr_led_jumper_regs (
  input  wire logic        clk_sys_i,
  input  wire logic        reset_i,
  input  wire logic [31:0] addr_i,
  input  wire logic [7:0]  wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [7:0]  rdata_o,
  input  wire logic        console_enable_jumper_i,
  input  wire logic        flash_write_enable_jumper_i,
  input  wire logic        console_swap_jumper_i,
  input  wire logic        first_user_jumper_i,
  input  wire logic        second_user_jumper_i,
  input  wire logic        flash_wr_req_i,
  output logic             flash_wr_en_o,
  output logic             led_red_o,
  output logic             led_green_o
);
  logic [7:0] led_r;
  logic [7:0] rd_nxt;
  logic [7:0] jmp_a;
  logic [7:0] jmp_b;

  ljsr_jumper_if jif ();

  ljsr_jumper_sample i_ljsr_jumper_sample (
    .clk_sys_i                   (clk_sys_i),
    .reset_i                     (reset_i),
    .console_enable_jumper_i     (console_enable_jumper_i),
    .flash_write_enable_jumper_i (flash_write_enable_jumper_i),
    .console_swap_jumper_i       (console_swap_jumper_i),
    .first_user_jumper_i         (first_user_jumper_i),
    .second_user_jumper_i        (second_user_jumper_i),
    .jmp                         (jif.src)
  );

  // jumper register images; unused bits zero
  always_comb begin
    jmp_a = ljsr_pkg::READ_ZERO;
    jmp_a[ljsr_pkg::CONSOLE_EN_BIT] = jif.console_enable_jumper;
    jmp_a[ljsr_pkg::FLASH_WE_BIT] = jif.flash_write_enable_jumper;
    jmp_a[ljsr_pkg::CONS_SWAP_BIT] = ~jif.console_swap_jumper;
    jmp_a[ljsr_pkg::USER1_BIT] = ~jif.first_user_jumper;
    jmp_b = ljsr_pkg::READ_ZERO;
    jmp_b[ljsr_pkg::USER2_BIT] = jif.second_user_jumper;
  end

  // led register; writes to jumper addresses fall through, ignored
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      led_r <= ljsr_pkg::LED_RESET;
    end else if (wr_i && addr_i == ljsr_pkg::LED_CTRL_ADDR) begin
      led_r <= wdata_i;
    end
  end

  // read mux; unmapped addresses read zero
  always_comb begin
    if (addr_i == ljsr_pkg::LED_CTRL_ADDR) begin
      rd_nxt = led_r;
    end else if (addr_i == ljsr_pkg::JUMPER_A_ADDR) begin
      rd_nxt = jmp_a;
    end else if (addr_i == ljsr_pkg::JUMPER_B_ADDR) begin
      rd_nxt = jmp_b;
    end else begin
      rd_nxt = ljsr_pkg::READ_ZERO;
    end
  end

  // read data valid only in the cycle after the strobe
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      rdata_o <= ljsr_pkg::READ_ZERO;
    end else if (rd_i) begin
      rdata_o <= rd_nxt;
    end else begin
      rdata_o <= ljsr_pkg::READ_ZERO;
    end
  end

  // led pins from the register, one flop late to keep outputs registered
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      led_red_o   <= 1'b1;
      led_green_o <= 1'b1;
    end else begin
      led_red_o   <= led_r[ljsr_pkg::LED_RED_BIT];
      led_green_o <= led_r[ljsr_pkg::LED_GREEN_BIT];
    end
  end

  // flash write gate: blocked unless the write-enable jumper is fitted
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      flash_wr_en_o <= 1'b0;
    end else begin
      flash_wr_en_o <= flash_wr_req_i
                       && jif.flash_write_enable_jumper;
    end
  end
endmodule

// ===== verif/ljsr_regs_assertions.sv
/* port checks for the led and jumper register bank; bound to its top */
`timescale 1ns/100ps
module ljsr_regs_assertions (
  input wire logic        clk_sys_i,
  input wire logic        reset_i,
  input wire logic        wr_i,
  input wire logic        rd_i,
  input wire logic        led_red_o,
  input wire logic        led_green_o,
  input wire logic        flash_wr_req_i,
  input wire logic        flash_wr_en_o,
  input wire logic        second_user_jumper_i,
  input wire logic        flash_write_enable_jumper_i,
  input wire logic [31:0] addr_i,
  input wire logic [7:0]  wdata_i,
  input wire logic [7:0]  rdata_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);
  wire logic fj = flash_write_enable_jumper_i;
  a_leds_reset: assert property (
    $fell(reset_i) |-> led_red_o && led_green_o) else $error("leds off");
  a_led_write: assert property (
    wr_i && addr_i == ljsr_pkg::LED_CTRL_ADDR |-> ##2 {led_red_o, led_green_o}
    == $past(wdata_i[1:0], 2)) else $error("led write");
  a_led_hold: assert property (
    !wr_i ##1 !wr_i |=> $stable({led_red_o, led_green_o})) else $error("led");
  a_jumper_a_zero: assert property (
    rd_i && addr_i == ljsr_pkg::JUMPER_A_ADDR |=> rdata_o[7:5] == 3'h0 &&
    !rdata_o[2]) else $error("jumper a");
  a_jumper_b: assert property (
    rd_i && addr_i == ljsr_pkg::JUMPER_B_ADDR && !$past(reset_i) &&
    $stable(second_user_jumper_i) |=> rdata_o == {7'h00,
    $past(second_user_jumper_i)}) else $error("jumper b");
  a_rd_idle: assert property (!rd_i |=> rdata_o == 8'h00) else $error("rd");
  a_flash_block: assert property (
    flash_wr_en_o |-> $past(fj, 2)) else $error("flash on");
  a_flash_open: assert property (
    flash_wr_req_i && fj && $stable(fj) && !$past(reset_i) |=> flash_wr_en_o)
    else $error("flash off");
endmodule
bind ljsr_led_jumper_regs ljsr_regs_assertions i_ljsr_regs_assertions (.*);

// ===== verif/ljsr_led_jumper_regs_tb_top.sv
/* bench for the register bank; drives its bus and jumper pins itself */
`timescale 1ns/100ps
module ljsr_led_jumper_regs_tb_top;
  logic        clk_sys_i = 1'b0, reset_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0;
  logic        flash_wr_req_i = 1'b1, flash_wr_en_o, led_red_o, led_green_o;
  logic [31:0] addr_i = 32'h0;
  logic [7:0]  wdata_i = 8'h00, rdata_o, v;
  logic [4:0]  pins = 5'h00;
  int          fail_count = 0, num_checks = 0, cycles = 0;
  always #4 clk_sys_i = ~clk_sys_i;
  ljsr_led_jumper_regs i_ljsr_led_jumper_regs (.clk_sys_i, .reset_i, .addr_i,
    .wdata_i, .wr_i, .rd_i, .rdata_o, .flash_wr_req_i, .flash_wr_en_o,
    .led_red_o, .led_green_o, .console_enable_jumper_i(pins[0]),
    .flash_write_enable_jumper_i(pins[1]), .console_swap_jumper_i(pins[2]),
    .first_user_jumper_i(pins[3]), .second_user_jumper_i(pins[4]));
  // hang guard, far beyond the 82 cycles the run takes
  always @(posedge clk_sys_i) if (++cycles == 900) test_done();
  task automatic check(string n, logic [7:0] s, logic [7:0] e);
    num_checks++;
    fail_count += int'(s !== e);
    if (s !== e) $display("mismatch %s expected %h seen %h", n, e, s);
  endtask
  task automatic acc(logic w, logic [31:0] a, logic [7:0] d);
    @(posedge clk_sys_i);
    {addr_i, wdata_i, wr_i, rd_i} <= {a, d, w, !w};
    @(posedge clk_sys_i);
    {wr_i, rd_i} <= 2'h0;
    #1;
  endtask
  task automatic test_done();
    fail_count += int'(cycles >= 900);
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // leds first, then jumper patterns with the flash gate riding along
  initial begin
    repeat (3) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    acc(1'b0, 32'h80840020, 8'h00);
    check("led reset", rdata_o, ljsr_pkg::LED_RESET);
    check("leds", {6'h00, led_red_o, led_green_o}, 8'h03);
    for (int i = 0; i < 5; i++) begin
      acc(1'b1, 32'h80840020, 8'(i * 41));
      acc(1'b0, 32'h80840020, 8'h00);
      check("led reg", rdata_o, 8'(i * 41));
      v = 8'(i * 41) & 8'h03;
      check("leds", {6'h00, led_red_o, led_green_o}, v);
    end
    // a neighbouring address must not reach the led register
    acc(1'b1, 32'h80840024, 8'hFF);
    acc(1'b0, 32'h80840024, 8'h00);
    check("unmapped", rdata_o, 8'h00);
    acc(1'b0, 32'h80840020, 8'h00);
    check("led kept", rdata_o, 8'hA4);
    // reset in mid-run while both leds are dark must light them again
    @(posedge clk_sys_i);
    reset_i <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    acc(1'b0, 32'h80840020, 8'h00);
    check("led reset", rdata_o, ljsr_pkg::LED_RESET);
    check("leds", {6'h00, led_red_o, led_green_o}, 8'h03);
    $display("led test done");
    // pins and request change on an edge; request gates the flash enable
    for (int i = 0; i < 5; i++) begin
      @(posedge clk_sys_i);
      pins           <= 5'(i * 7);
      flash_wr_req_i <= 1'(i);
      acc(1'b1, 32'h10800000, 8'hFF);
      acc(1'b0, 32'h10800000, 8'h00);
      v = {3'h0, ~pins[3:2], 1'h0, pins[1:0]};
      check("jumper a", rdata_o, v);
      v = {7'h00, pins[1] & flash_wr_req_i};
      check("flash", {7'h00, flash_wr_en_o}, v);
      acc(1'b1, 32'h22800000, 8'hFF);
      acc(1'b0, 32'h22800000, 8'h00);
      check("jumper b", rdata_o, {7'h00, pins[4]});
    end
    $display("jumper test done");
    test_done();
  end
endmodule
